// *** hdl/psb_pkg.sv ***
// Constants and carrier types for the position scaling parameter bank.
// Assumes parameter addresses are fieldbus register numbers, one whole value each.
package psb_pkg;

   // ==========================================================
   // Parameter addresses
   localparam logic [15:0] ADDR_SCALE_DIVISOR    = 16'h060E;
   localparam logic [15:0] ADDR_SCALE_MULTIPLIER = 16'h0610;
   localparam logic [15:0] ADDR_ROTATION_SENSE   = 16'h0618;
   localparam logic [15:0] ADDR_PROFILE_SPEED    = 16'h1B1E;
   localparam logic [15:0] ADDR_MOVE_ORIGIN      = 16'h1B30;

   // ==========================================================
   // Reset values and accepted ranges
   localparam logic [31:0] RST_SCALE_DIVISOR    = 32'h0000_4000;
   localparam logic [31:0] RST_SCALE_MULTIPLIER = 32'h0000_0001;
   localparam logic [15:0] RST_ROTATION_SENSE   = 16'h0000;
   localparam logic [31:0] RST_PROFILE_SPEED    = 32'h0000_003C;
   localparam logic [15:0] RST_MOVE_ORIGIN      = 16'h0000;
   localparam logic [31:0] SCALE_MIN            = 32'h0000_0001;
   localparam logic [31:0] SCALE_MAX            = 32'h7FFF_FFFF;
   localparam logic [31:0] SPEED_MIN            = 32'h0000_0001;
   localparam logic [15:0] SENSE_MAX            = 16'h0001;
   localparam logic [15:0] ORIGIN_PREV_TARGET   = 16'h0000;
   localparam logic [15:0] ORIGIN_ACTUAL_POS    = 16'h0002;

   // ==========================================================
   // Exception codes and conversion limits
   localparam logic [7:0]  EXC_NONE          = 8'h00;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
   localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [6:0]  DIV_STEPS         = 7'h40;
   localparam logic [31:0] POS_SAT           = 32'h7FFF_FFFF;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [31:0] wdata;
   } psb_req_t;

   typedef struct packed {
      logic        ack;
      logic        exc;
      logic [7:0]  exc_code;
      logic [31:0] rdata;
   } psb_resp_t;

endpackage

// *** hdl/psb_divider.sv ***
// Unsigned 64 by 32 restoring divider, one quotient bit per clock.
// Assumes the divisor is nonzero and start is only raised while idle.
`timescale 1ns/100ps

module psb_divider (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        start,
   input  wire logic [63:0] dividend,
   input  wire logic [31:0] divisor,
   output logic             busy,
   output logic             done,
   output logic [63:0]      quotient
);

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [6:0]  cnt;
      logic [31:0] dsr;
      logic [32:0] rem;
      logic [63:0] quo;
   } psb_div_state_t;

   psb_div_state_t st_r;
   psb_div_state_t st_nxt;
   logic [32:0]    shifted;

   // ==========================================================
   // Step logic: shift one dividend bit in, subtract when it fits
   always_comb begin
      st_nxt  = st_r;
      shifted = {st_r.rem[31:0], st_r.quo[63]};
      st_nxt.done = 1'b0;
      if (start && !st_r.busy) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt  = psb_pkg::DIV_STEPS;
         st_nxt.dsr  = divisor;
         st_nxt.rem  = 33'h0_0000_0000;
         st_nxt.quo  = dividend;
      end else if (st_r.busy) begin
         st_nxt.quo = {st_r.quo[62:0], 1'b0};
         st_nxt.rem = shifted;
         if (shifted >= {1'b0, st_r.dsr}) begin
            st_nxt.rem    = shifted - {1'b0, st_r.dsr};
            st_nxt.quo[0] = 1'b1;
         end
         st_nxt.cnt = st_r.cnt - 7'h01;
         if (st_r.cnt == 7'h01) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy     = st_r.busy;
   assign done     = st_r.done;
   assign quotient = st_r.quo;

endmodule // psb_divider

// *** hdl/psb_param_bank.sv ***
// Position scaling parameter bank: five fieldbus parameters and their effects.
// Assumes one request per cycle from the fieldbus front end, synchronous inputs.
`timescale 1ns/100ps

module psb_param_bank (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire psb_pkg::psb_req_t req,
   output psb_pkg::psb_resp_t     resp,
   input  wire logic [31:0]       speed_ceiling,
   input  wire logic [31:0]       speed_cmd,
   output logic [31:0]            motor_speed_cmd,
   output logic [31:0]            profile_speed_eff,
   output logic                   origin_actual_pos,
   input  wire logic              conv_start,
   input  wire logic              conv_to_user,
   input  wire logic [31:0]       conv_in,
   output logic                   conv_busy,
   output logic                   conv_done,
   output logic [31:0]            conv_out
);

   typedef struct packed {
      logic [31:0]        divisor;      // Stored, not yet active
      logic [31:0]        multiplier;
      logic [31:0]        act_divisor;  // Pair in use by conversions
      logic [31:0]        act_multiplier;
      logic [15:0]        sense;        // Stored rotation sense
      logic               sense_active;
      logic               powered;
      logic [31:0]        speed;
      logic [15:0]        origin;
      psb_pkg::psb_resp_t resp;
      logic [31:0]        motor_speed;
      logic [31:0]        speed_eff;
      logic               conv_busy;
      logic               conv_neg;
      logic               conv_done;
      logic [31:0]        conv_out;
   } psb_state_t;

   psb_state_t  st_r;
   psb_state_t  st_nxt;
   logic        div_start;
   logic [63:0] div_dividend;
   logic [31:0] div_divisor;
   logic        div_busy;
   logic        div_done;
   logic [63:0] div_quo;
   logic [31:0] in_mag;
   logic [31:0] q_mag;
   logic        wr_ok;
   logic        hit;

   // ==========================================================
   // Shared divider for position conversion
   // The start edge loads the divider, 64 quotient steps follow, and done is
   // registered once more here, so the result stands 65 edges after the start
   // edge. One divider serves both directions to save area; a second request
   // while busy is simply dropped, so the master must wait for conv_done.
   psb_divider u_div (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .start    (div_start),
      .dividend (div_dividend),
      .divisor  (div_divisor),
      .busy     (div_busy),
      .done     (div_done),
      .quotient (div_quo)
   );

   // Magnitude of the position to convert; the most negative value maps to 2^31
   assign in_mag = conv_in[31] ? (32'h0000_0000 - conv_in) : conv_in;

   // Toward motor: pos * mult / div; toward user: pos * div / mult
   assign div_start    = conv_start && !st_r.conv_busy;
   assign div_dividend = in_mag * (conv_to_user ? st_r.act_divisor
                                                : st_r.act_multiplier);
   assign div_divisor  = conv_to_user ? st_r.act_multiplier : st_r.act_divisor;

   // Quotients beyond 31 bits saturate rather than wrap
   assign q_mag = (div_quo[63:31] != 33'h0_0000_0000) ? psb_pkg::POS_SAT
                                                       : div_quo[31:0];

   // ==========================================================
   // Request decode, range checks and side effects
   always_comb begin
      st_nxt = st_r;
      wr_ok  = 1'b0;
      hit    = 1'b1;
      st_nxt.resp = '0;

      // Rotation sense is taken once after power-up, then frozen
      st_nxt.powered = 1'b1;
      if (!st_r.powered) begin
         st_nxt.sense_active = st_r.sense[0];
      end

      if (req.valid) begin
         st_nxt.resp.ack = 1'b1;
         unique case (req.addr)
            psb_pkg::ADDR_SCALE_DIVISOR: begin
               st_nxt.resp.rdata = st_r.divisor;
               wr_ok = (req.wdata >= psb_pkg::SCALE_MIN)
                    && (req.wdata <= psb_pkg::SCALE_MAX);
               if (req.write && wr_ok) begin
                  st_nxt.divisor = req.wdata;
               end
            end
            psb_pkg::ADDR_SCALE_MULTIPLIER: begin
               st_nxt.resp.rdata = st_r.multiplier;
               wr_ok = (req.wdata >= psb_pkg::SCALE_MIN)
                    && (req.wdata <= psb_pkg::SCALE_MAX);
               if (req.write && wr_ok) begin
                  st_nxt.multiplier     = req.wdata;
                  st_nxt.act_multiplier = req.wdata;
                  st_nxt.act_divisor    = st_r.divisor;
               end
            end
            psb_pkg::ADDR_ROTATION_SENSE: begin
               st_nxt.resp.rdata = {16'h0000, st_r.sense};
               wr_ok = (req.wdata[31:16] == 16'h0000)
                    && (req.wdata[15:0] <= psb_pkg::SENSE_MAX);
               if (req.write && wr_ok) begin
                  st_nxt.sense = req.wdata[15:0];
               end
            end
            psb_pkg::ADDR_PROFILE_SPEED: begin
               st_nxt.resp.rdata = st_r.speed;
               wr_ok = (req.wdata >= psb_pkg::SPEED_MIN);
               if (req.write && wr_ok) begin
                  st_nxt.speed = req.wdata;
               end
            end
            psb_pkg::ADDR_MOVE_ORIGIN: begin
               st_nxt.resp.rdata = {16'h0000, st_r.origin};
               wr_ok = (req.wdata == {16'h0000, psb_pkg::ORIGIN_PREV_TARGET})
                    || (req.wdata == {16'h0000, psb_pkg::ORIGIN_ACTUAL_POS});
               if (req.write && wr_ok) begin
                  st_nxt.origin = req.wdata[15:0];
               end
            end
            default: begin
               hit = 1'b0;
            end
         endcase

         // Refused writes leave storage alone and answer with an exception
         if (!hit) begin
            st_nxt.resp.exc      = 1'b1;
            st_nxt.resp.exc_code = psb_pkg::EXC_ILLEGAL_ADDR;
            st_nxt.resp.rdata    = 32'h0000_0000;
         end else if (req.write && !wr_ok) begin
            st_nxt.resp.exc      = 1'b1;
            st_nxt.resp.exc_code = psb_pkg::EXC_ILLEGAL_VALUE;
         end
      end

      // Sign follows the active sense; the most negative command wraps to itself
      st_nxt.motor_speed = st_r.sense_active ? (32'h0000_0000 - speed_cmd)
                                             : speed_cmd;

      // Ceiling applies live, so lowering it slows the next move without a rewrite
      st_nxt.speed_eff = (st_r.speed > speed_ceiling) ? speed_ceiling
                                                      : st_r.speed;

      // Conversion bookkeeping around the divider
      st_nxt.conv_done = 1'b0;
      if (div_start) begin
         st_nxt.conv_busy = 1'b1;
         st_nxt.conv_neg  = conv_in[31];
      end else if (div_done) begin
         st_nxt.conv_busy = 1'b0;
         st_nxt.conv_done = 1'b1;
         st_nxt.conv_out  = st_r.conv_neg ? (32'h0000_0000 - q_mag) : q_mag;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r                <= '0;
         st_r.divisor        <= psb_pkg::RST_SCALE_DIVISOR;
         st_r.multiplier     <= psb_pkg::RST_SCALE_MULTIPLIER;
         st_r.act_divisor    <= psb_pkg::RST_SCALE_DIVISOR;
         st_r.act_multiplier <= psb_pkg::RST_SCALE_MULTIPLIER;
         st_r.sense          <= psb_pkg::RST_ROTATION_SENSE;
         st_r.speed          <= psb_pkg::RST_PROFILE_SPEED;
         st_r.speed_eff      <= psb_pkg::RST_PROFILE_SPEED;
         st_r.origin         <= psb_pkg::RST_MOVE_ORIGIN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops except conv_busy (a handshake) and origin_actual_pos (decoded)
   assign resp              = st_r.resp;
   assign motor_speed_cmd   = st_r.motor_speed;
   assign profile_speed_eff = st_r.speed_eff;
   assign origin_actual_pos = (st_r.origin == psb_pkg::ORIGIN_ACTUAL_POS);
   assign conv_busy         = st_r.conv_busy || div_busy;
   assign conv_done         = st_r.conv_done;
   assign conv_out          = st_r.conv_out;

endmodule // psb_param_bank

// *** verification/psb_param_bank_sva.sv ***
// Port checker for the parameter bank.
// Assumes binding to psb_param_bank, one clock, async low reset.
`timescale 1ns/100ps
module psb_param_bank_sva (
   input wire logic              core_clk,
   input wire logic              arst_n,
   input wire psb_pkg::psb_req_t  req,
   input wire psb_pkg::psb_resp_t resp,
   input wire logic [31:0]       speed_ceiling,
   input wire logic [31:0]       profile_speed_eff,
   input wire logic              conv_start,
   input wire logic              conv_busy,
   input wire logic              conv_done
);
   // ==========================================
   // Helpers
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic wr;
   logic ev;
   assign wr = req.valid && req.write;
   assign ev = resp.exc && resp.exc_code == psb_pkg::EXC_ILLEGAL_VALUE;
   // ==========================================
   // Answer timing and refusals
   property p_ack; req.valid |=> resp.ack; endproperty
   a_ack: assert property (p_ack) else $error("request unanswered");
   property p_quiet; !req.valid |=> !resp.ack; endproperty
   a_quiet: assert property (p_quiet) else $error("spurious answer");
   property p_sense; wr && req.addr == psb_pkg::ADDR_ROTATION_SENSE && req.wdata > 32'h1 |=> ev;
   endproperty
   a_sense: assert property (p_sense) else $error("sense above 1 taken");
   property p_div; wr && req.addr == psb_pkg::ADDR_SCALE_DIVISOR && req.wdata == 32'h0 |=> ev;
   endproperty
   a_div: assert property (p_div) else $error("zero divisor taken");
   property p_mult; wr && req.addr == psb_pkg::ADDR_SCALE_MULTIPLIER && req.wdata[31] |=> ev;
   endproperty
   a_mult: assert property (p_mult) else $error("negative multiplier taken");
   property p_speed; wr && req.addr == psb_pkg::ADDR_PROFILE_SPEED && req.wdata == 32'h0 |=> ev;
   endproperty
   a_speed: assert property (p_speed) else $error("zero speed taken");
   property p_origin; wr && req.addr == psb_pkg::ADDR_MOVE_ORIGIN && req.wdata == 32'h1 |=> ev;
   endproperty
   a_origin: assert property (p_origin) else $error("origin 1 taken");
   // Clamp uses the ceiling seen one edge earlier
   property p_clamp; profile_speed_eff <= $past(speed_ceiling); endproperty
   a_clamp: assert property (p_clamp) else $error("speed above ceiling");
   // Divider done lands on the edge of its last step, then is registered once more
   property p_conv; conv_start && !conv_busy |-> ##66 conv_done; endproperty
   a_conv: assert property (p_conv) else $error("conversion not done at 66");
   property p_busy; conv_start && !conv_busy |=> conv_busy [*8]; endproperty
   a_busy: assert property (p_busy) else $error("busy dropped early");
endmodule // psb_param_bank_sva

// *** verification/psb_fieldbus_master.sv ***
// Fieldbus master model: issues one whole request per call.
// Assumes the answer stands in the cycle after the taking edge.
`timescale 1ns/100ps
module psb_fieldbus_master (
   input  wire logic               core_clk,
   output psb_pkg::psb_req_t       req,
   input  wire psb_pkg::psb_resp_t resp
);
   initial req = '{valid: 1'b0, write: 1'b1, addr: 16'hFFFF, wdata: 32'hFFFF_FFFF};
   // ==========================================
   // Access; released lines show the inverse so stale data cannot pass
   task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                         output psb_pkg::psb_resp_t r);
      @(negedge core_clk);
      req = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(negedge core_clk);
      r = resp;
      req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
   endtask
endmodule // psb_fieldbus_master

// *** verification/tb_position_scaling_param_bank.sv ***
// Self-checking bench for the parameter bank.
// Assumes psb_pkg, the master model and the checker compile first.
`timescale 1ns/100ps
`define CHK(g, e) cmp((g) === (e))
module tb_position_scaling_param_bank;
   logic               core_clk, arst_n, conv_start, conv_to_user;
   logic               conv_busy, conv_done, origin_actual_pos;
   logic [31:0]        speed_ceiling, speed_cmd, motor_speed_cmd, profile_speed_eff;
   logic [31:0]        conv_in, conv_out;
   psb_pkg::psb_req_t  req;
   psb_pkg::psb_resp_t resp, r;
   int                 n_mismatch = 0, checked = 0, cyc = 0;
   logic [15:0] adr [5] = '{16'h060E, 16'h0610, 16'h0618, 16'h1B1E, 16'h1B30};
   logic [31:0] rst [5] = '{32'h4000, 32'h1, 32'h0, 32'h3C, 32'h0};
   logic [31:0] bad [5] = '{32'h0, 32'h8000_0000, 32'h2, 32'h0, 32'h1};

   psb_param_bank uut (.core_clk(core_clk), .arst_n(arst_n), .req(req), .resp(resp),
      .speed_ceiling(speed_ceiling), .speed_cmd(speed_cmd),
      .motor_speed_cmd(motor_speed_cmd), .profile_speed_eff(profile_speed_eff),
      .origin_actual_pos(origin_actual_pos), .conv_start(conv_start),
      .conv_to_user(conv_to_user), .conv_in(conv_in), .conv_busy(conv_busy),
      .conv_done(conv_done), .conv_out(conv_out));
   psb_fieldbus_master mst (.core_clk(core_clk), .req(req), .resp(resp));

   // ==========================================
   // Clock, timeout and verdict
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input bit ok);
      checked++;
      if (!ok) begin
         n_mismatch++;
         $display("[FAIL] %0t compare %0d differs", $time, checked);
      end
   endtask
   task automatic acc(input logic w, input int i, input logic [31:0] d);
      mst.access(w, adr[i], d, r);
   endtask
   // Conversion; done is awaited under a bound
   task automatic conv(input logic u, input logic [31:0] x, input logic [31:0] e);
      int n;
      @(negedge core_clk);
      conv_start = 1'b1;
      conv_to_user = u;
      conv_in = x;
      @(negedge core_clk);
      conv_start = 1'b0;
      n = 0;
      while (conv_done !== 1'b1 && n < 80) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(conv_done, 1'b1);
      `CHK(conv_out, e);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      conv_start = 1'b0;
      conv_to_user = 1'b0;
      conv_in = 32'h0;
      speed_ceiling = 32'h1000;
      speed_cmd = 32'h64;
      repeat (2) @(negedge core_clk);
      arst_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, i, 32'h0);
         `CHK(r.rdata, rst[i]);
         acc(1'b1, i, bad[i]);
         `CHK(r.exc_code, psb_pkg::EXC_ILLEGAL_VALUE);
         acc(1'b0, i, 32'h0);
         `CHK(r.rdata, rst[i]);
      end
      mst.access(1'b0, 16'h0612, 32'h0, r);
      `CHK(r.exc_code, psb_pkg::EXC_ILLEGAL_ADDR);
      // Sense is stored but motion keeps the power-up sense
      acc(1'b1, 2, 32'h1);
      acc(1'b0, 2, 32'h0);
      `CHK(r.rdata, 32'h1);
      `CHK(motor_speed_cmd, 32'h64);
      acc(1'b1, 4, 32'h2);
      `CHK(origin_actual_pos, 1'b1);
      acc(1'b1, 4, 32'h0);
      `CHK(origin_actual_pos, 1'b0);
      acc(1'b1, 3, 32'h64);
      speed_ceiling = 32'h50;
      repeat (2) @(negedge core_clk);
      `CHK(profile_speed_eff, 32'h50);
      speed_ceiling = 32'hC8;
      repeat (2) @(negedge core_clk);
      `CHK(profile_speed_eff, 32'h64);
      conv(1'b0, 32'h4000, 32'h1);
      acc(1'b1, 0, 32'h4);
      conv(1'b0, 32'h4000, 32'h1);
      acc(1'b1, 1, 32'h3);
      conv(1'b0, 32'h8, 32'h6);
      conv(1'b1, 32'h6, 32'h8);
      conv(1'b0, 32'hFFFF_FFF8, 32'hFFFF_FFFA);
      acc(1'b1, 0, 32'h1);
      acc(1'b1, 1, 32'h7FFF_FFFF);
      conv(1'b0, 32'h2, 32'h7FFF_FFFF);
      close_out();
   end
endmodule // tb_position_scaling_param_bank

bind psb_param_bank psb_param_bank_sva chk (.core_clk(core_clk), .arst_n(arst_n),
   .req(req), .resp(resp), .speed_ceiling(speed_ceiling),
   .profile_speed_eff(profile_speed_eff), .conv_start(conv_start),
   .conv_busy(conv_busy), .conv_done(conv_done));
